//--- rtl/stom_pkg.sv
package stom_pkg;
   // Clock and timing figures
   localparam longint CLK_PERIOD_NS = 5;
   localparam longint TOL_TIME_NS = 1000000000;    // 1 s single-channel tolerance
   localparam longint LATCH_TIME_NS = 3000000000;  // 3 s discrepancy latch
   // Longest time rounds down
   localparam int unsigned TOL_CYC = int'(TOL_TIME_NS / CLK_PERIOD_NS);
   // Least time rounds up
   localparam int unsigned LATCH_CYC = int'((LATCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int CNT_W = 30;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFF_SPEED = 8'h10;

   // Status field positions
   localparam int ST_TRIP_BIT = 0;
   localparam int ST_LATCH_BIT = 1;
   localparam int ST_FB_BIT = 2;
   localparam int ST_TORQUE_BIT = 3;
   localparam int ST_CHA_BIT = 4;
   localparam int ST_CHB_BIT = 5;
   localparam int ST_STATE_LSB = 8;

   // Interrupt field positions
   localparam int IRQ_TRIP_BIT = 0;
   localparam int IRQ_LATCH_BIT = 1;
   localparam int IRQ_FB_BIT = 2;
   localparam int IRQ_W = 3;

   // Reset values and ramp
   localparam logic [15:0] SETPOINT_RST = 16'h0000;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
   localparam logic [15:0] RAMP_STEP = 16'h0001;

   // Drive states, Gray along idle-run-ramp-trip
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN = 2'h1,
      ST_RAMP = 2'h3,
      ST_TRIP = 2'h2
   } stom_state_e;
endpackage

//--- rtl/stom_top.sv
`timescale 1ns/10ps
module stom_top #(
   parameter int unsigned TOL_CYC = stom_pkg::TOL_CYC,
   parameter int unsigned LATCH_CYC = stom_pkg::LATCH_CYC
) (
   input wire logic clk_i,                       // 200 MHz clock
   input wire logic rst_i,                       // Power-up reset, sync, high
   input wire logic wb_cyc_i,                    // Wishbone cycle
   input wire logic wb_stb_i,                    // Wishbone strobe
   input wire logic wb_we_i,                     // Wishbone write enable
   input wire logic [7:0] wb_adr_i,              // Byte address
   input wire logic [3:0] wb_sel_i,              // Byte lanes
   input wire logic [31:0] wb_dat_i,             // Write data
   output logic [31:0] wb_dat_o,                 // Read data
   output logic wb_ack_o,                        // Acknowledge
   input wire logic channel_a_demand_input_i,    // Channel A demand, high energised
   input wire logic channel_b_demand_input_i,    // Channel B demand, high energised
   input wire logic run_cmd_i,                   // Run command level
   input wire logic stop_cmd_i,                  // Stop command level
   output logic torque_enable_o,                 // Power stage torque enable
   output logic ramp_down_o,                     // Controlled decel active
   output logic [15:0] speed_ref_o,              // Speed reference to stage
   output logic trip_o,                          // Torque-off trip indication
   output logic fault_latch_o,                   // Discrepancy fault latch
   output logic torque_off_feedback_a_o,         // Feedback contact A
   output logic torque_off_feedback_b_o,         // Feedback contact B
   output logic irq_o                            // Level interrupt
);

   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [3:0] prev_q;
   logic cha_s;
   logic chb_s;
   logic both_ok;
   logic run_rise;
   logic stop_rise;
   logic [stom_pkg::CNT_W-1:0] mis_cnt_q;
   logic late_q;
   logic latch_q;
   logic fb_q;
   stom_pkg::stom_state_e state_q;
   stom_pkg::stom_state_e state_d;
   logic [15:0] speed_q;
   logic [15:0] setpoint_q;
   logic [stom_pkg::IRQ_W-1:0] irq_stat_q;
   logic [stom_pkg::IRQ_W-1:0] irq_mask_q;
   logic [stom_pkg::IRQ_W-1:0] irq_ev;
   logic ack_q;
   logic [31:0] rdat_q;
   logic wr_stb;
   logic [31:0] status_w;

   // input sync
   // Two stages on every pin; logic reads stage two and, for edges, its delayed copy
   // Channel stages reset energised so power-up shows no false trip;
   // a channel truly low at release still trips three edges later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 4'h3;
         sync2_q <= 4'h3;
         prev_q <= 4'h0;
      end else begin
         sync1_q <= {stop_cmd_i, run_cmd_i, channel_b_demand_input_i,
                     channel_a_demand_input_i};
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   assign cha_s = sync2_q[0];
   assign chb_s = sync2_q[1];
   assign both_ok = cha_s & chb_s;
   // Edges so a held run command starts the drive only once
   assign run_rise = sync2_q[2] & ~prev_q[2];
   assign stop_rise = sync2_q[3] & ~prev_q[3];

   // discrepancy timer
   // Counts while the channels disagree, saturates past the latch point
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mis_cnt_q <= '0;
      end else if (cha_s == chb_s) begin
         mis_cnt_q <= '0;
      end else if (mis_cnt_q <= stom_pkg::CNT_W'(LATCH_CYC)) begin
         mis_cnt_q <= mis_cnt_q + 1'b1;
      end
   end

   // Mismatch beyond tolerance marks a later dual removal unhealthy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         late_q <= 1'b0;
      end else if (both_ok) begin
         late_q <= 1'b0;
      end else if (mis_cnt_q >= stom_pkg::CNT_W'(TOL_CYC)) begin
         late_q <= 1'b1;
      end
   end

   // only reset clears it, so a power cycle is needed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch_q <= 1'b0;
      end else if (mis_cnt_q == stom_pkg::CNT_W'(LATCH_CYC)) begin
         latch_q <= 1'b1;
      end
   end

   // drops as soon as either channel returns
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fb_q <= 1'b0;
      end else begin
         fb_q <= ~cha_s & ~chb_s & ~latch_q & ~late_q;
      end
   end

   // Drive sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         stom_pkg::ST_IDLE: begin
            if (!both_ok) begin
               state_d = stom_pkg::ST_TRIP;
            end else if (run_rise) begin
               state_d = stom_pkg::ST_RUN;
            end
         end
         stom_pkg::ST_RUN: begin
            if (!both_ok) begin
               state_d = stom_pkg::ST_TRIP;
            end else if (stop_rise) begin
               state_d = stom_pkg::ST_RAMP;
            end
         end
         stom_pkg::ST_RAMP: begin
            if (!both_ok) begin
               state_d = stom_pkg::ST_TRIP;
            end else if (run_rise) begin
               state_d = stom_pkg::ST_RUN;
            end else if (speed_q == 16'h0000) begin
               state_d = stom_pkg::ST_IDLE;
            end
         end
         stom_pkg::ST_TRIP: begin
            if (both_ok && !latch_q && run_rise) begin
               state_d = stom_pkg::ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= stom_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Speed ramp; torque loss means coast, reference forced to zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         speed_q <= 16'h0000;
      end else if (state_d == stom_pkg::ST_TRIP || state_d == stom_pkg::ST_IDLE) begin
         speed_q <= 16'h0000;
      end else if (state_d == stom_pkg::ST_RAMP || speed_q > setpoint_q) begin
         speed_q <= (speed_q > stom_pkg::RAMP_STEP) ? speed_q - stom_pkg::RAMP_STEP : 16'h0000;
      end else if (speed_q < setpoint_q) begin
         speed_q <= (setpoint_q - speed_q > stom_pkg::RAMP_STEP) ?
                    speed_q + stom_pkg::RAMP_STEP : setpoint_q;
      end
   end

   // trip flag follows state, cleared only by a restart or by reset
   assign trip_o = (state_q == stom_pkg::ST_TRIP);
   assign torque_enable_o = (state_q == stom_pkg::ST_RUN) || (state_q == stom_pkg::ST_RAMP);
   assign ramp_down_o = (state_q == stom_pkg::ST_RAMP);
   assign speed_ref_o = speed_q;
   assign fault_latch_o = latch_q;
   assign torque_off_feedback_a_o = fb_q;
   assign torque_off_feedback_b_o = fb_q;

   // Events feeding the sticky status
   assign irq_ev[stom_pkg::IRQ_TRIP_BIT] = (state_d == stom_pkg::ST_TRIP) &&
                                           (state_q != stom_pkg::ST_TRIP);
   assign irq_ev[stom_pkg::IRQ_LATCH_BIT] = (mis_cnt_q == stom_pkg::CNT_W'(LATCH_CYC)) &&
                                            !latch_q;
   assign irq_ev[stom_pkg::IRQ_FB_BIT] = ~cha_s & ~chb_s & ~latch_q & ~late_q & ~fb_q;

   // Bus write strobe at the edge the master samples ack
   assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

   // Sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= '0;
      end else if (wr_stb && wb_adr_i[7:2] == stom_pkg::OFF_IRQ_STAT[7:2] && wb_sel_i[0]) begin
         irq_stat_q <= (irq_stat_q & ~wb_dat_i[stom_pkg::IRQ_W-1:0]) | irq_ev;
      end else begin
         irq_stat_q <= irq_stat_q | irq_ev;
      end
   end

   // Control and mask registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         setpoint_q <= stom_pkg::SETPOINT_RST;
         irq_mask_q <= stom_pkg::IRQ_MASK_RST;
      end else if (wr_stb) begin
         if (wb_adr_i[7:2] == stom_pkg::OFF_CTRL[7:2]) begin
            if (wb_sel_i[0]) begin
               setpoint_q[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               setpoint_q[15:8] <= wb_dat_i[15:8];
            end
         end
         if (wb_adr_i[7:2] == stom_pkg::OFF_IRQ_MASK[7:2] && wb_sel_i[0]) begin
            irq_mask_q <= wb_dat_i[stom_pkg::IRQ_W-1:0];
         end
      end
   end

   assign irq_o = |(irq_stat_q & irq_mask_q);

   // Status word
   always_comb begin
      status_w = 32'h0000_0000;
      status_w[stom_pkg::ST_TRIP_BIT] = trip_o;
      status_w[stom_pkg::ST_LATCH_BIT] = latch_q;
      status_w[stom_pkg::ST_FB_BIT] = fb_q;
      status_w[stom_pkg::ST_TORQUE_BIT] = torque_enable_o;
      status_w[stom_pkg::ST_CHA_BIT] = cha_s;
      status_w[stom_pkg::ST_CHB_BIT] = chb_s;
      status_w[stom_pkg::ST_STATE_LSB +: 2] = state_q;
   end

   // One wait state: ack and data registered, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
         if (wb_cyc_i && wb_stb_i && !ack_q) begin
            unique case (wb_adr_i[7:2])
               stom_pkg::OFF_CTRL[7:2]: rdat_q <= {16'h0000, setpoint_q};
               stom_pkg::OFF_STATUS[7:2]: rdat_q <= status_w;
               stom_pkg::OFF_IRQ_STAT[7:2]: rdat_q <= {29'h0, irq_stat_q};
               stom_pkg::OFF_IRQ_MASK[7:2]: rdat_q <= {29'h0, irq_mask_q};
               stom_pkg::OFF_SPEED[7:2]: rdat_q <= {16'h0000, speed_q};
               default: rdat_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // Checks on the guarded behaviour
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence both_gone_s;
      !cha_s && !chb_s;
   endsequence

   sequence restart_s;
      trip_o && both_ok && !latch_q && run_rise;
   endsequence

   cha_loss_trip_a: assert property (
      (!cha_s && chb_s) |=> (trip_o && !torque_enable_o && !torque_off_feedback_a_o))
      else $error("channel A loss did not trip");
   chb_loss_trip_a: assert property (
      (cha_s && !chb_s) |=> (trip_o && !torque_enable_o && !torque_off_feedback_b_o))
      else $error("channel B loss did not trip");
   restart_clears_a: assert property (
      restart_s |=> (torque_enable_o && !trip_o && !torque_off_feedback_a_o))
      else $error("restart did not clear trip");
   latch_sets_a: assert property (
      (cha_s != chb_s) [*2] ##0 (mis_cnt_q == stom_pkg::CNT_W'(LATCH_CYC)) |=>
      (fault_latch_o && !torque_enable_o && !torque_off_feedback_a_o))
      else $error("discrepancy latch not set");
   latch_blocks_a: assert property (
      fault_latch_o |=> (fault_latch_o && trip_o && !torque_enable_o && !fb_q))
      else $error("drive ran with fault latch set");
   power_cycle_a: assert property (
      @(posedge clk_i) disable iff (1'b0)
      rst_i |=> (!fault_latch_o && !trip_o && !torque_off_feedback_a_o))
      else $error("reset did not clear the latch");
   dual_feedback_a: assert property (
      (both_gone_s ##0 !latch_q && !late_q) |=> (torque_off_feedback_a_o &&
      torque_off_feedback_b_o && !fault_latch_o))
      else $error("dual removal gave no feedback");
   dual_ignore_run_a: assert property (
      both_gone_s [*2] |-> (trip_o && !torque_enable_o))
      else $error("run accepted with inputs removed");
   reconnect_fb_a: assert property (
      $rose(both_ok) |=> !torque_off_feedback_a_o)
      else $error("feedback stayed on after reconnect");
   trip_holds_a: assert property (
      (trip_o && !run_rise) |=> trip_o)
      else $error("trip cleared without restart");
   stop_ramps_a: assert property (
      (state_q == stom_pkg::ST_RUN && both_ok && stop_rise) |=>
      (ramp_down_o && torque_enable_o && !trip_o))
      else $error("stop did not ramp");
   power_up_clean_a: assert property (
      $fell(rst_i) |=> (!trip_o && !fault_latch_o && !torque_off_feedback_a_o))
      else $error("power-up reported a trip");
   mis_timer_a: assert property (
      (cha_s != chb_s && mis_cnt_q < stom_pkg::CNT_W'(LATCH_CYC)) |=>
      (mis_cnt_q == $past(mis_cnt_q) + stom_pkg::CNT_W'(1)))
      else $error("discrepancy timer did not count");
endmodule

//--- sim/stom_ctrl_model.sv
`timescale 1ns/10ps
// Safety controller and run command source facing the monitor
module stom_ctrl_model (
   input wire logic clk_i, // Bench clock
   output logic cha_o,     // Channel A demand, high energised
   output logic chb_o,     // Channel B demand, high energised
   output logic run_o,     // Run command level
   output logic stop_o     // Stop command level
);
   // Energised and idle from time zero, so power-up sees no trip
   initial begin
      cha_o = 1'b1;
      chb_o = 1'b1;
      run_o = 1'b0;
      stop_o = 1'b0;
   end

   // selected channels removed, B the given skew after A
   // Callers keep skew under the tolerance count
   task automatic drop(input logic a, input logic b, input int skew);
      @(posedge clk_i);
      if (a) cha_o <= 1'b0;
      repeat (skew) @(posedge clk_i);
      if (b) chb_o <= 1'b0;
   endtask

   // Both channels back together
   task automatic restore();
      @(posedge clk_i);
      cha_o <= 1'b1;
      chb_o <= 1'b1;
   endtask

   // Command pulse; trailing low cycle keeps edges apart
   task automatic pulse(input logic stop, input int hold);
      @(posedge clk_i);
      if (stop) stop_o <= 1'b1;
      else run_o <= 1'b1;
      repeat (hold) @(posedge clk_i);
      stop_o <= 1'b0;
      run_o <= 1'b0;
      @(posedge clk_i);
   endtask
endmodule

//--- sim/tb_stom_top.sv
`timescale 1ns/10ps
// Self-checking bench for the torque-off monitor
module tb_stom_top;
   // Short counts keep the run brief
   localparam int unsigned TOL = 20;
   localparam int unsigned LAT = 60;
   localparam logic [7:0] CTL = stom_pkg::OFF_CTRL;
   localparam logic [7:0] STS = stom_pkg::OFF_STATUS;
   localparam logic [7:0] IRS = stom_pkg::OFF_IRQ_STAT;
   localparam logic [7:0] MSK = stom_pkg::OFF_IRQ_MASK;
   localparam logic [7:0] SPD = stom_pkg::OFF_SPEED;
   localparam stom_pkg::stom_state_e S_ID = stom_pkg::ST_IDLE;
   localparam stom_pkg::stom_state_e S_RN = stom_pkg::ST_RUN;
   localparam stom_pkg::stom_state_e S_RP = stom_pkg::ST_RAMP;
   localparam stom_pkg::stom_state_e S_TR = stom_pkg::ST_TRIP;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h00000000;
   logic [31:0] rdat;
   logic ack, cha, chb, run, stp, tq, rmp, trp, lat, fba, fbb, irq;
   logic [15:0] spd_ref;
   logic [15:0] sp;
   logic [6:0] pins;
   logic [31:0] exp_d[$];
   logic [6:0] exp_p[$];
   logic [31:0] exp_w;
   int n_errors = 0;
   int checked = 0;
   int cycles = 0;

   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;

   stom_top #(.TOL_CYC(TOL), .LATCH_CYC(LAT)) u_stom_top (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .channel_a_demand_input_i(cha), .channel_b_demand_input_i(chb),
      .run_cmd_i(run), .stop_cmd_i(stp), .torque_enable_o(tq), .ramp_down_o(rmp),
      .speed_ref_o(spd_ref), .trip_o(trp), .fault_latch_o(lat),
      .torque_off_feedback_a_o(fba), .torque_off_feedback_b_o(fbb), .irq_o(irq));

   stom_ctrl_model u_stom_ctrl_model (
      .clk_i(clk_i), .cha_o(cha), .chb_o(chb), .run_o(run), .stop_o(stp));

   // Pin snapshot compared with every read answer
   assign pins = {rmp, irq, tq, fbb, fba, lat, trp};

   function automatic logic [31:0] st(input logic tr, input logic la, input logic fb,
                                      input logic t, input logic a, input logic b,
                                      input stom_pkg::stom_state_e s);
      logic [31:0] v;
      v = 32'h00000000;
      v[stom_pkg::ST_TRIP_BIT] = tr;
      v[stom_pkg::ST_LATCH_BIT] = la;
      v[stom_pkg::ST_FB_BIT] = fb;
      v[stom_pkg::ST_TORQUE_BIT] = t;
      v[stom_pkg::ST_CHA_BIT] = a;
      v[stom_pkg::ST_CHB_BIT] = b;
      v[stom_pkg::ST_STATE_LSB +: 2] = s;
      return v;
   endfunction

   // Both feedback contacts are expected identical
   function automatic logic [6:0] pv(input logic tr, input logic la, input logic fb,
                                     input logic t, input logic iq, input logic rp);
      return {rp, iq, t, fb, fb, la, tr};
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Classic cycle; held until ack is sampled, then released
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [6:0] p);
      @(posedge clk_i);
      if (!w) begin
         exp_d.push_back(d);
         exp_p.push_back(p);
      end
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= w ? d : 32'h00000000;
      do @(posedge clk_i); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [6:0] p);
      bus(1'b0, a, d, p);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 7'h00);
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Reset stands for a power cycle
   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask

   task automatic report_and_stop();
      if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Oldest note is compared when a read answer appears
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0) begin
         if (exp_d.size() == 0) check("unexpected read", 32'h1, 32'h0);
         else begin
            exp_w = exp_d.pop_front();
            check("read data", rdat, exp_w);
            check("pins", {25'h0, pins}, {25'h0, exp_p.pop_front()});
            // Speed pin must agree with the register read at rest or at setpoint
            if (adr == SPD) check("speed pin", {16'h0, spd_ref}, exp_w);
         end
      end
   end

   // A hung wait ends the run as a failure
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   initial begin
      void'($urandom(11439));
      sp = 16'($urandom & 32'h00FF) | 16'h0040;
      do_reset();
      // Power-up with both channels energised, then a plain start
      rd(STS, st(0, 0, 0, 0, 1, 1, S_ID), 7'h00);
      rd(MSK, 32'h0, 7'h00);
      rd(8'h20, 32'h0, 7'h00);
      wr(CTL, {16'h0, sp});
      rd(CTL, {16'h0, sp}, 7'h00);
      u_stom_ctrl_model.pulse(1'b0, 2);
      wait_n(300);
      rd(STS, st(0, 0, 0, 1, 1, 1, S_RN), pv(0, 0, 0, 1, 0, 0));
      // Brief loss of each channel; interrupt masked on the second
      for (int ch = 0; ch < 2; ch++) begin
         wr(MSK, (ch == 0) ? 32'h1 : 32'h0);
         u_stom_ctrl_model.drop(ch == 0, ch == 1, 0);
         wait_n(8);
         rd(STS, st(1, 0, 0, 0, ch == 1, ch == 0, S_TR), pv(1, 0, 0, 0, ch == 0, 0));
         rd(IRS, 32'h1, pv(1, 0, 0, 0, ch == 0, 0));
         u_stom_ctrl_model.restore();
         wait_n(8);
         rd(STS, st(1, 0, 0, 0, 1, 1, S_TR), pv(1, 0, 0, 0, ch == 0, 0));
         wr(IRS, 32'h7);
         rd(IRS, 32'h0, pv(1, 0, 0, 0, 0, 0));
         u_stom_ctrl_model.pulse(1'b0, 2);
         wait_n(300);
         rd(STS, st(0, 0, 0, 1, 1, 1, S_RN), pv(0, 0, 0, 1, 0, 0));
         rd(SPD, {16'h0, sp}, pv(0, 0, 0, 1, 0, 0));
      end
      // Long single loss latches until a power cycle
      for (int ch = 0; ch < 2; ch++) begin
         u_stom_ctrl_model.drop(ch == 0, ch == 1, 0);
         wait_n(LAT + 20);
         rd(STS, st(1, 1, 0, 0, ch == 1, ch == 0, S_TR), pv(1, 1, 0, 0, 0, 0));
         u_stom_ctrl_model.restore();
         u_stom_ctrl_model.pulse(1'b0, 2);
         wait_n(20);
         rd(STS, st(1, 1, 0, 0, 1, 1, S_TR), pv(1, 1, 0, 0, 0, 0));
         rd(IRS, 32'h3, pv(1, 1, 0, 0, 0, 0));
         do_reset();
         rd(STS, st(0, 0, 0, 0, 1, 1, S_ID), 7'h00);
         rd(CTL, 32'h0, 7'h00);
         wr(CTL, {16'h0, sp});
         u_stom_ctrl_model.pulse(1'b0, 2);
         wait_n(300);
         rd(STS, st(0, 0, 0, 1, 1, 1, S_RN), pv(0, 0, 0, 1, 0, 0));
      end
      // Dual removal with a short skew
      u_stom_ctrl_model.drop(1'b1, 1'b1, 3);
      wait_n(10);
      rd(STS, st(1, 0, 1, 0, 0, 0, S_TR), pv(1, 0, 1, 0, 0, 0));
      u_stom_ctrl_model.pulse(1'b0, 50);
      rd(STS, st(1, 0, 1, 0, 0, 0, S_TR), pv(1, 0, 1, 0, 0, 0));
      wait_n(LAT + 20);
      rd(STS, st(1, 0, 1, 0, 0, 0, S_TR), pv(1, 0, 1, 0, 0, 0));
      u_stom_ctrl_model.restore();
      wait_n(8);
      rd(STS, st(1, 0, 0, 0, 1, 1, S_TR), pv(1, 0, 0, 0, 0, 0));
      u_stom_ctrl_model.pulse(1'b0, 2);
      wait_n(300);
      rd(SPD, {16'h0, sp}, pv(0, 0, 0, 1, 0, 0));
      // Normal stop ramps down with torque kept
      u_stom_ctrl_model.pulse(1'b1, 3);
      rd(STS, st(0, 0, 0, 1, 1, 1, S_RP), pv(0, 0, 0, 1, 0, 1));
      wait_n(300);
      rd(STS, st(0, 0, 0, 0, 1, 1, S_ID), 7'h00);
      rd(SPD, 32'h0, 7'h00);
      wait_n(4);
      report_and_stop();
   end
endmodule
